/* File: flash_dev_model.sv */
// Behavioural flash device: status byte, sleep, abort, programming.
// Assumes strobes change only at rising edges of clk.
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int BUSY_CYC = 100  // Program time, shortened for the run
) (
    input  wire logic        clk,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        fail_cmd,  // Next program ends in failure
    input  wire logic        protect,   // Sector-protect state
    input  wire logic        lockout,   // Supply below lockout level
    output logic [7:0]       rd_data,
    output logic             rdy
);
    logic [7:0]  st = 8'h80;           // Ready, suspend, fails, sleep
    logic        stat_mode = 1'b0;     // Reads return status
    logic [1:0]  seq = 2'd0;           // Unlock progress
    int          busy = 0;             // Program cycles left
    logic        pwe = 1'b1;
    logic        pce = 1'b1;
    logic        prd = 1'b1;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  snap = 8'h00;
    logic [7:0]  last = 8'h00;
    logic [19:0] wa = 20'h0;
    // Released bus shows the inverse, so stale data never matches
    assign rd_data = (!ce_n && !oe_n) ? snap : ~last;
    assign rdy = st[7];
    // ==========================================================
    // Pin sampling, one cycle behind the strobes
    // ==========================================================
    always @(posedge clk) begin
        // end of program sets ready, and the program fail bit when fail_cmd is high
        if (busy == 1) begin
            st[7] = 1'b1;
            st[4] = st[4] | fail_cmd;
        end
        if (busy > 0) busy--;
        if (lockout) begin
            busy = 0;
            stat_mode = 1'b0;
            seq = 2'd0;
        end
        if (prd && !ce_n && !oe_n) begin
            snap = stat_mode ? {st[7:4], protect, st[2], 2'b00} : 8'h3C;
            last = snap;
        end
        // Command taken at the rising write strobe
        // writes dropped under lockout
        if (!pwe && we_n && !pce && oe_n && !lockout) begin
            if (wd == 8'h70) stat_mode = 1'b1;
            else if (wd == 8'h50) st[5:4] = 2'b00;
            else if (wd == 8'hF0) begin
                stat_mode = 1'b0;
                st[2] = 1'b0;
            end else if (seq == 2'd2 && wa == 20'h00555) begin
                // program refused while a fail stands
                if (wd == 8'hA0 && st[5:4] == 2'b00) begin
                    busy = BUSY_CYC;
                    st[7] = 1'b0;
                    stat_mode = 1'b1;
                end
                if (wd == 8'hC0 && !st[6]) st[2] = 1'b1;
                if (wd == 8'hE0 && busy > 0) begin
                    busy = 0;
                    st = st | 8'h94;
                    stat_mode = 1'b1;
                end
            end
            seq = (wd == 8'hAA && wa == 20'h00555) ? 2'd1 :
                  (seq == 2'd1 && wd == 8'h55 && wa == 20'h002AA) ? 2'd2 :
                  2'd0;
        end
        if (!we_n) wd = wr_data;
        if (!we_n) wa = addr;
        pwe = we_n;
        pce = ce_n;
        prd = ce_n | oe_n;
    end
endmodule // flash_dev_model

/* File: flash_host_ctrl.sv */
// Host controller for the status, sleep and abort side of a parallel
// flash. Assumes the flash strobes are driven only by this block.
//
// Contract
// - Host toggles strobes for every status read
// - No program or erase while fail set
// - Host masks the two reserved status bits
// - Sleep entered by three writes ending C0
`timescale 1ns/1ps

module flash_host_ctrl #(
    parameter logic [19:0] UNLOCK_ADDR1 = 20'h00555, // Plain default
    parameter logic [19:0] UNLOCK_ADDR2 = 20'h002AA, // Plain default
    parameter logic [7:0]  UNLOCK_DATA1 = 8'hAA,     // Plain default
    parameter logic [7:0]  UNLOCK_DATA2 = 8'h55,     // Plain default
    parameter logic [7:0]  CODE_RD_STAT = 8'h70,     // Plain default
    parameter logic [7:0]  CODE_CLR_STAT = 8'h50,    // Plain default
    parameter logic [7:0]  CODE_RD_ARRAY = 8'hF0     // Plain default
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // User side
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_cmd,
    input  wire logic [7:0]  req_data,
    output logic             req_ready,
    output logic             done,
    output logic             refused,
    output logic [7:0]       status,
    output logic             fail_seen,
    output logic             flash_ready,
    // Flash pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [19:0]      addr,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe,
    input  wire logic [7:0]  data_lines_in,
    input  wire logic        ready_busy_pin
);

    // ==========================================================
    // Types and state
    // ==========================================================
    typedef enum logic [2:0] {
        S_IDLE,    // Waiting for a request
        S_WLOW,    // Write strobe low
        S_WGAP,    // Strobes high after a write
        S_RLOW,    // Read strobes low, waiting for data
        S_RGAP     // Strobes high between reads
    } state_t;
    typedef flash_host_pkg::req_t req_t;  // User request codes

    state_t      state_r,   state_nxt;     // Sequencer state
    logic [3:0]  cnt_r,     cnt_nxt;       // Cycle counter
    logic [1:0]  step_r,    step_nxt;      // Current write of sequence
    logic [1:0]  last_r,    last_nxt;      // Index of final write
    logic [7:0]  final_r,   final_nxt;     // Final command byte
    req_t        cmd_r,     cmd_nxt;       // Request in progress
    logic        ce_n_r,    ce_n_nxt;
    logic        oe_n_r,    oe_n_nxt;
    logic        we_n_r,    we_n_nxt;
    logic [19:0] addr_r,    addr_nxt;
    logic [7:0]  dout_r,    dout_nxt;
    logic        doe_r,     doe_nxt;
    logic        rdy_r,     rdy_nxt;
    logic        done_r,    done_nxt;
    logic        ref_r,     ref_nxt;
    logic [7:0]  status_r,  status_nxt;
    logic        fail_r,    fail_nxt;

    // Pin synchronisers; first stage read only by the second
    logic [7:0]  dq_s1_r, dq_s2_r;
    logic        rb_s1_r, rb_s2_r;

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Address of a write step; only the last one carries the code
    function automatic logic [19:0] step_addr(input logic [1:0] s,
                                              input logic [1:0] l);
        if (s == l)
            step_addr = UNLOCK_ADDR1;
        else if (s == 2'h0)
            step_addr = UNLOCK_ADDR1;
        else
            step_addr = UNLOCK_ADDR2;
    endfunction

    function automatic logic [7:0] step_data(input logic [1:0] s,
                                             input logic [1:0] l,
                                             input logic [7:0] f);
        if (s == l)
            step_data = f;
        else if (s == 2'h0)
            step_data = UNLOCK_DATA1;
        else
            step_data = UNLOCK_DATA2;
    endfunction

    // ==========================================================
    // Pin input synchronisers
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
        end else begin
            dq_s1_r <= data_lines_in;
            dq_s2_r <= dq_s1_r;
            rb_s1_r <= ready_busy_pin;
            rb_s2_r <= rb_s1_r;
        end
    end

    // ==========================================================
    // Sequencer next state
    // ==========================================================
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        step_nxt   = step_r;
        last_nxt   = last_r;
        final_nxt  = final_r;
        cmd_nxt    = cmd_r;
        ce_n_nxt   = ce_n_r;
        oe_n_nxt   = oe_n_r;
        we_n_nxt   = we_n_r;
        addr_nxt   = addr_r;
        dout_nxt   = dout_r;
        doe_nxt    = doe_r;
        done_nxt   = 1'b0;
        ref_nxt    = 1'b0;
        status_nxt = status_r;
        fail_nxt   = fail_r;
        case (state_r)
            S_IDLE: begin
                if (req_valid) begin
                    cmd_nxt  = req_t'(req_cmd);
                    step_nxt = 2'h0;
                    last_nxt = 2'h2;
                    case (req_t'(req_cmd))
                        flash_host_pkg::REQ_READ_STATUS: begin
                            last_nxt  = 2'h0;
                            final_nxt = CODE_RD_STAT;
                        end
                        flash_host_pkg::REQ_CLEAR_STATUS: begin
                            last_nxt  = 2'h0;
                            final_nxt = CODE_CLR_STAT;
                        end
                        flash_host_pkg::REQ_READ_ARRAY: begin
                            last_nxt  = 2'h0;
                            final_nxt = CODE_RD_ARRAY;
                        end
                        flash_host_pkg::REQ_SLEEP: begin
                            final_nxt = flash_host_pkg::CODE_SLEEP;
                        end
                        flash_host_pkg::REQ_ABORT: begin
                            final_nxt = flash_host_pkg::CODE_ABORT;
                        end
                        default: begin
                            final_nxt = req_data;
                        end
                    endcase
                    if (req_t'(req_cmd) == flash_host_pkg::REQ_POLL) begin
                        // Device already in status mode
                        state_nxt = S_RLOW;
                        ce_n_nxt  = 1'b0;
                        oe_n_nxt  = 1'b0;
                        cnt_nxt   = 4'(flash_host_pkg::ACCESS_CYC
                                       + flash_host_pkg::SYNC_CYC);
                    // no program or erase after fail
                    end else if (req_t'(req_cmd) == flash_host_pkg::REQ_SEQ3
                        && fail_r
                        && (req_data == flash_host_pkg::CODE_PROGRAM
                         || req_data == flash_host_pkg::CODE_SETUP)) begin
                        ref_nxt = 1'b1;
                    end else begin
                        // Start first write of the sequence
                        state_nxt = S_WLOW;
                        ce_n_nxt  = 1'b0;
                        we_n_nxt  = 1'b0;
                        doe_nxt   = 1'b1;
                        addr_nxt  = step_addr(2'h0, last_nxt);
                        dout_nxt  = step_data(2'h0, last_nxt, final_nxt);
                        cnt_nxt   = 4'(flash_host_pkg::WE_LOW_CYC);
                    end
                end
            end
            S_WLOW: begin
                // Data latched by the device on the rising strobe
                if (cnt_r > 4'h1) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else begin
                    state_nxt = S_WGAP;
                    we_n_nxt  = 1'b1;
                    ce_n_nxt  = 1'b1;
                    cnt_nxt   = 4'(flash_host_pkg::WR_GAP_CYC);
                end
            end
            S_WGAP: begin
                if (cnt_r > 4'h1) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else if (step_r != last_r) begin
                    // Next write of a multi-write sequence
                    step_nxt  = step_r + 2'h1;
                    state_nxt = S_WLOW;
                    ce_n_nxt  = 1'b0;
                    we_n_nxt  = 1'b0;
                    addr_nxt  = step_addr(step_r + 2'h1, last_r);
                    dout_nxt  = step_data(step_r + 2'h1, last_r, final_r);
                    cnt_nxt   = 4'(flash_host_pkg::WE_LOW_CYC);
                end else if (cmd_r == flash_host_pkg::REQ_READ_STATUS) begin
                    // Release bus, then read status
                    doe_nxt   = 1'b0;
                    state_nxt = S_RLOW;
                    ce_n_nxt  = 1'b0;
                    oe_n_nxt  = 1'b0;
                    cnt_nxt   = 4'(flash_host_pkg::ACCESS_CYC
                                   + flash_host_pkg::SYNC_CYC);
                end else begin
                    doe_nxt   = 1'b0;
                    state_nxt = S_IDLE;
                    done_nxt  = 1'b1;
                    // only clear-status drops the fail flag
                    if (cmd_r == flash_host_pkg::REQ_CLEAR_STATUS)
                        fail_nxt = 1'b0;
                end
            end
            S_RLOW: begin
                // Wait access time plus synchroniser depth
                if (cnt_r > 4'h1) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else begin
                    status_nxt = dq_s2_r & flash_host_pkg::ST_MASK;
                    // fail bits mark a refused engine
                    if (dq_s2_r[flash_host_pkg::ST_EFAIL]
                        || dq_s2_r[flash_host_pkg::ST_PFAIL])
                        fail_nxt = 1'b1;
                    // strobes high before the next read
                    ce_n_nxt  = 1'b1;
                    oe_n_nxt  = 1'b1;
                    state_nxt = S_RGAP;
                    cnt_nxt   = 4'(flash_host_pkg::RD_GAP_CYC);
                end
            end
            S_RGAP: begin
                if (cnt_r > 4'h1) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else if (cmd_r == flash_host_pkg::REQ_POLL
                             && !status_r[flash_host_pkg::ST_READY]) begin
                    // fresh falling edge per poll read
                    state_nxt = S_RLOW;
                    ce_n_nxt  = 1'b0;
                    oe_n_nxt  = 1'b0;
                    cnt_nxt   = 4'(flash_host_pkg::ACCESS_CYC
                                   + flash_host_pkg::SYNC_CYC);
                end else begin
                    state_nxt = S_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = S_IDLE;
                ce_n_nxt  = 1'b1;
                oe_n_nxt  = 1'b1;
                we_n_nxt  = 1'b1;
                doe_nxt   = 1'b0;
            end
        endcase
        // Ready only when the next cycle is idle
        rdy_nxt = (state_nxt == S_IDLE) && !(state_r == S_IDLE && req_valid);
    end

    // ==========================================================
    // Sequencer registers
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= S_IDLE;
            cnt_r    <= 4'h0;
            step_r   <= 2'h0;
            last_r   <= 2'h0;
            final_r  <= 8'h00;
            cmd_r    <= flash_host_pkg::REQ_READ_STATUS;
            ce_n_r   <= 1'b1;
            oe_n_r   <= 1'b1;
            we_n_r   <= 1'b1;
            addr_r   <= 20'h00000;
            dout_r   <= 8'h00;
            doe_r    <= 1'b0;
            rdy_r    <= 1'b0;
            done_r   <= 1'b0;
            ref_r    <= 1'b0;
            status_r <= flash_host_pkg::ST_RESET;
            fail_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            step_r   <= step_nxt;
            last_r   <= last_nxt;
            final_r  <= final_nxt;
            cmd_r    <= cmd_nxt;
            ce_n_r   <= ce_n_nxt;
            oe_n_r   <= oe_n_nxt;
            we_n_r   <= we_n_nxt;
            addr_r   <= addr_nxt;
            dout_r   <= dout_nxt;
            doe_r    <= doe_nxt;
            rdy_r    <= rdy_nxt;
            done_r   <= done_nxt;
            ref_r    <= ref_nxt;
            status_r <= status_nxt;
            fail_r   <= fail_nxt;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    // ==========================================================
    assign req_ready      = rdy_r;
    assign done           = done_r;
    assign refused        = ref_r;
    assign status         = status_r;
    assign fail_seen      = fail_r;
    assign flash_ready    = rb_s2_r;
    assign ce_n           = ce_n_r;
    assign oe_n           = oe_n_r;
    assign we_n           = we_n_r;
    assign addr           = addr_r;
    assign data_lines_out = dout_r;
    assign data_lines_oe  = doe_r;

endmodule // flash_host_ctrl

/* File: flash_host_ctrl_checker.sv */
// Checker for the flash host controller: strobes, status and flags.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module flash_host_ctrl_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       done,
    input wire logic       refused,
    input wire logic [7:0] status,
    input wire logic       fail_seen,
    input wire logic       ce_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic       data_lines_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Strobe shapes
    // ==========================================================
    // Read: strobes low twelve cycles (access plus sync), then released
    sequence read_low_s;
        !oe_n [*8] ##1 !oe_n [*4] ##1 oe_n;
    endsequence
    // Write: strobe low four cycles, then released
    sequence write_low_s;
        !we_n [*4] ##1 we_n;
    endsequence
    low_bits_zero_a: assert property (status[1:0] == 2'h0)
        else $error("status low bits not masked");
    read_hold_a: assert property ($fell(oe_n) |-> read_low_s)
        else $error("read strobe width wrong");
    read_gap_a: assert property ($rose(oe_n) |-> oe_n [*2])
        else $error("read strobes not toggled");
    write_pulse_a: assert property ($fell(we_n) |-> write_low_s)
        else $error("write strobe width wrong");
    write_cycle_a: assert property (!we_n |->
        oe_n && !ce_n && data_lines_oe)
        else $error("write cycle malformed");
    read_bus_free_a: assert property (!oe_n |-> !data_lines_oe)
        else $error("host drives bus during read");
    refuse_cond_a: assert property (refused |->
        $past(fail_seen) && ce_n && we_n)
        else $error("refusal without fail");
    status_latch_a: assert property ($changed(status) |-> $rose(oe_n))
        else $error("status changed outside read end");
    fail_set_a: assert property ($rose(fail_seen) |->
        (status[5] || status[4]))
        else $error("fail flag set without fail bit");
    fail_clear_a: assert property ($fell(fail_seen) |-> done)
        else $error("fail flag cleared outside clear");
endmodule // flash_host_ctrl_checker

bind flash_host_ctrl flash_host_ctrl_checker u_chk (
    .clk(clk), .rst_n(rst_n), .done(done), .refused(refused),
    .status(status), .fail_seen(fail_seen), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .data_lines_oe(data_lines_oe));

/* File: flash_host_pkg.sv */
// Constants shared by the flash status and sleep host controller.
// Assumes a 40 MHz system clock and an 8-bit parallel flash data bus.
package flash_host_pkg;

    // ==========================================================
    // Clock and bus timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 25;     // 40 MHz clock
    localparam int T_WE_LOW_NS   = 100;    // Write strobe low time
    localparam int T_WR_GAP_NS   = 50;     // Strobes high between writes
    localparam int T_ACCESS_NS   = 250;    // Read access before sampling
    localparam int T_RD_GAP_NS   = 50;     // Strobes high between reads
    // Least times, rounded up to whole cycles
    localparam int WE_LOW_CYC  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int WR_GAP_CYC  = (T_WR_GAP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int ACCESS_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int RD_GAP_CYC  = (T_RD_GAP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int SYNC_CYC    = 2;        // Data synchroniser depth

    // ==========================================================
    // Command codes written as the final byte
    // ==========================================================
    localparam logic [7:0] CODE_SLEEP   = 8'hC0;
    localparam logic [7:0] CODE_ABORT   = 8'hE0;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_SETUP   = 8'h80;

    // ==========================================================
    // Status byte fields
    // ==========================================================
    localparam int ST_READY   = 7;
    localparam int ST_SUSPEND = 6;
    localparam int ST_EFAIL   = 5;
    localparam int ST_PFAIL   = 4;
    localparam int ST_PROTECT = 3;
    localparam int ST_SLEEP   = 2;
    localparam logic [7:0] ST_MASK  = 8'hFC;  // Reserved low bits dropped
    localparam logic [7:0] ST_RESET = 8'h80;  // Ready, no faults

    // ==========================================================
    // User requests
    // ==========================================================
    typedef enum logic [2:0] {
        REQ_READ_STATUS,   // Read-status command, then one status read
        REQ_POLL,          // Status reads until ready
        REQ_CLEAR_STATUS,  // Clear-status command
        REQ_READ_ARRAY,    // Read-array command, wakes from sleep
        REQ_SLEEP,         // Three-write sleep sequence
        REQ_ABORT,         // Three-write abort sequence
        REQ_SEQ3           // Three-write sequence, user final byte
    } req_t;

endpackage

/* File: test_flash_host_ctrl.sv */
// Self-checking bench for the flash host controller.
// Assumes the device model on the pins and the bound checker.
`timescale 1ns/1ps
module test_flash_host_ctrl;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic [2:0]  req_cmd = 3'h0;
    logic [7:0]  req_data = 8'h00;
    logic        req_ready, done, refused, fail_seen, flash_ready;
    logic        ce_n, oe_n, we_n, dl_oe, rb;
    logic [7:0]  status, dl_out, dl_in;
    logic [19:0] addr;
    logic        fail_cmd = 1'b0;  // Model told to fail next program
    logic        lockout = 1'b0;   // Supply below lockout level
    logic [9:0]  exp_q[$];         // Notes: refused, fail flag, status
    logic [9:0]  e;
    logic [31:0] rnd = 32'h6;      // Xorshift state
    int          errors = 0;
    int          n_checks = 0;
    flash_host_ctrl i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_data(req_data), .req_ready(req_ready),
        .done(done), .refused(refused), .status(status),
        .fail_seen(fail_seen), .flash_ready(flash_ready), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .addr(addr), .data_lines_out(dl_out),
        .data_lines_oe(dl_oe), .data_lines_in(dl_in), .ready_busy_pin(rb));
    flash_dev_model #(.BUSY_CYC(100)) i_dev (.clk(clk), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .addr(addr), .wr_data(dl_out),
        .fail_cmd(fail_cmd), .protect(1'b1), .lockout(lockout),
        .rd_data(dl_in), .rdy(rb));
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One request: wait for ready, note the outcome, pulse valid
    task automatic req(input logic [2:0] c, input logic [7:0] d,
                       input logic [9:0] x);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 3000);
        if (req_ready !== 1'b1) begin
            errors++;
            end_sim();
        end
        exp_q.push_back(x);
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_data <= d;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    // Clock, 25 ns period
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Watcher: oldest note against each done or refused pulse
    always @(negedge clk) begin
        if (done === 1'b1 || refused === 1'b1) begin
            e = 10'h3FF;
            if (exp_q.size() > 0) e = exp_q.pop_front();
            chk1(refused, e[9]);
            chk1(fail_seen, e[8]);
            chk8(status, e[7:0]);
        end
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h088);
        // Unknown final codes leave status alone
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            req(flash_host_pkg::REQ_SEQ3, {2'b00, rnd[5:0]}, 10'h088);
        end
        $display("test power-up and random codes ended");
        fail_cmd <= 1'b1;
        req(flash_host_pkg::REQ_SEQ3, 8'hA0, 10'h088);
        req(flash_host_pkg::REQ_POLL, 8'h00, 10'h198);
        req(flash_host_pkg::REQ_SEQ3, 8'hA0, 10'h398);
        req(flash_host_pkg::REQ_SEQ3, 8'h80, 10'h398);
        req(flash_host_pkg::REQ_CLEAR_STATUS, 8'h00, 10'h098);
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h088);
        $display("test program fail ended");
        fail_cmd <= 1'b0;
        req(flash_host_pkg::REQ_SEQ3, 8'hA0, 10'h088);
        req(flash_host_pkg::REQ_ABORT, 8'h00, 10'h088);
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h19C);
        req(flash_host_pkg::REQ_CLEAR_STATUS, 8'h00, 10'h09C);
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h08C);
        req(flash_host_pkg::REQ_READ_ARRAY, 8'h00, 10'h08C);
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h088);
        $display("test abort ended");
        req(flash_host_pkg::REQ_SEQ3, 8'hA0, 10'h088);
        req(flash_host_pkg::REQ_SLEEP, 8'h00, 10'h088);
        req(flash_host_pkg::REQ_POLL, 8'h00, 10'h08C);
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(negedge clk);
        if (exp_q.size() > 0) errors++;
        repeat (4) @(negedge clk);
        chk1(flash_ready, 1'b1);
        $display("test sleep ended");
        // Command write ignored, so the read shows array data
        lockout <= 1'b1;
        req(flash_host_pkg::REQ_READ_STATUS, 8'h00, 10'h13C);
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(negedge clk);
        if (exp_q.size() > 0) errors++;
        $display("test lockout ended");
        end_sim();
    end
endmodule // test_flash_host_ctrl
